// ### core/alc_hyst_cmp.sv
// one threshold comparator with hysteresis on the 13-bit light reading
// assumes thresholds are stable between readings; inputs come from the same clock
`timescale 1ns/10ps
module alc_hyst_cmp #(
  parameter int unsigned SHIFT = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reading and settings
  input wire alc_pkg::alc_sample_t sample,
  input wire logic enable,
  input wire logic [7:0] threshold,
  input wire logic [7:0] hysteresis,
  // result
  output logic tripped
);

  logic next_tripped;
  logic [alc_pkg::SAMPLE_W-1:0] trip_level;
  logic [alc_pkg::SAMPLE_W-1:0] release_level;

  // sum is 9 bits at most, so even shifted by three it fits the reading width
  assign trip_level = alc_pkg::SAMPLE_W'({5'h00, threshold} << SHIFT);
  assign release_level = alc_pkg::SAMPLE_W'(({5'h00, threshold} + {5'h00, hysteresis}) << SHIFT);

  always_comb begin
    next_tripped = tripped;
    if (!enable) begin
      next_tripped = 1'b0;
    end else if (sample.valid) begin
      if (sample.value < trip_level) begin
        next_tripped = 1'b1;
      end else if (sample.value > release_level) begin
        next_tripped = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tripped <= 1'b0;
    end else begin
      tripped <= next_tripped;
    end
  end

endmodule : alc_hyst_cmp

// ### core/alc_level_cmp.sv
// ambient light level comparator: threshold registers, two comparators, level select
// assumes a register port driven by the on-chip serial interface and a converter pulse per reading
//
// Functional notes
// (RL1) reading below office threshold selects office level
// (RL2) office threshold is 4.3 uA per code
// (RL3) above office threshold plus hysteresis returns daylight
// (RL4) office hysteresis is 4.3 uA per code
// (RL5) software keeps office codes at most 250
// (RL6) software keeps office sum at most 250
// (RL7) reading below dark threshold selects dark level
// (RL8) dark threshold is 0.54 uA per code
// (RL9) dark level wins over office level
// (RL10) compare 13-bit reading, refreshed each 80 ms
// (RL11) leave dark above dark threshold plus hysteresis
`timescale 1ns/10ps
module alc_level_cmp (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // sensor reading and comparator enables
  input wire alc_pkg::alc_sample_t light_sensor_input,
  input wire logic office_compare_enable,
  input wire logic dark_compare_enable,
  // results
  output logic office_tripped,
  output logic dark_tripped,
  output alc_pkg::alc_level_t backlight_level
);

  logic [7:0] office_threshold;
  logic [7:0] office_hysteresis;
  logic [7:0] dark_threshold;
  logic [7:0] dark_hysteresis;
  logic [7:0] next_office_threshold;
  logic [7:0] next_office_hysteresis;
  logic [7:0] next_dark_threshold;
  logic [7:0] next_dark_hysteresis;
  logic [7:0] next_reg_rdata;
  alc_pkg::alc_level_t next_backlight_level;

  // register file; codes above 250 are stored as written, keeping them sane is software's job
  always_comb begin
    next_office_threshold = office_threshold;
    next_office_hysteresis = office_hysteresis;
    next_dark_threshold = dark_threshold;
    next_dark_hysteresis = dark_hysteresis;
    next_reg_rdata = reg_rdata;
    if (reg_write) begin
      unique case (reg_addr)
        alc_pkg::OFS_OFFICE_THRESHOLD: next_office_threshold = reg_wdata;
        alc_pkg::OFS_OFFICE_HYSTERESIS: next_office_hysteresis = reg_wdata;
        alc_pkg::OFS_DARK_THRESHOLD: next_dark_threshold = reg_wdata;
        alc_pkg::OFS_DARK_HYSTERESIS: next_dark_hysteresis = reg_wdata;
        default: ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        alc_pkg::OFS_OFFICE_THRESHOLD: next_reg_rdata = office_threshold;
        alc_pkg::OFS_OFFICE_HYSTERESIS: next_reg_rdata = office_hysteresis;
        alc_pkg::OFS_DARK_THRESHOLD: next_reg_rdata = dark_threshold;
        alc_pkg::OFS_DARK_HYSTERESIS: next_reg_rdata = dark_hysteresis;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      office_threshold <= alc_pkg::RST_OFFICE_THRESHOLD;
      office_hysteresis <= alc_pkg::RST_OFFICE_HYSTERESIS;
      dark_threshold <= alc_pkg::RST_DARK_THRESHOLD;
      dark_hysteresis <= alc_pkg::RST_DARK_HYSTERESIS;
      reg_rdata <= alc_pkg::RST_READ_DATA;
    end else begin
      office_threshold <= next_office_threshold;
      office_hysteresis <= next_office_hysteresis;
      dark_threshold <= next_dark_threshold;
      dark_hysteresis <= next_dark_hysteresis;
      reg_rdata <= next_reg_rdata;
    end
  end

  // office codes scale by eight into reading steps; judged only on a fresh reading
  alc_hyst_cmp #(
    .SHIFT(alc_pkg::OFFICE_SHIFT)
  ) u_office_cmp (
    .clk(clk),
    .rst(rst),
    .sample(light_sensor_input), // [RL1] [RL2] [RL3] [RL4] [RL10]
    .enable(office_compare_enable),
    .threshold(office_threshold),
    .hysteresis(office_hysteresis),
    .tripped(office_tripped)
  );

  // dark codes are already in reading steps
  alc_hyst_cmp #(
    .SHIFT(alc_pkg::DARK_SHIFT)
  ) u_dark_cmp (
    .clk(clk),
    .rst(rst),
    .sample(light_sensor_input), // [RL7] [RL8] [RL10] [RL11]
    .enable(dark_compare_enable),
    .threshold(dark_threshold),
    .hysteresis(dark_hysteresis),
    .tripped(dark_tripped)
  );

  // level follows the comparators one cycle later, so it is always a clean register
  always_comb begin
    if (dark_tripped) begin
      next_backlight_level = alc_pkg::ALC_LVL_DARK; // [RL9]
    end else if (office_tripped) begin
      next_backlight_level = alc_pkg::ALC_LVL_OFFICE;
    end else begin
      next_backlight_level = alc_pkg::ALC_LVL_DAYLIGHT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backlight_level <= alc_pkg::ALC_LVL_DAYLIGHT;
    end else begin
      backlight_level <= next_backlight_level;
    end
  end

  // checks
  logic [12:0] office_trip_s;
  logic [12:0] office_rel_s;
  logic [12:0] dark_rel_s;
  assign office_trip_s = {2'h0, office_threshold, 3'h0};
  assign office_rel_s = {1'h0, ({1'h0, office_threshold} + {1'h0, office_hysteresis}), 3'h0};
  assign dark_rel_s = {4'h0, ({1'h0, dark_threshold} + {1'h0, dark_hysteresis})};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_OFFICE_TRIP: assert property ( // [RL1]
    light_sensor_input.valid && office_compare_enable && light_sensor_input.value < office_trip_s
    |=> office_tripped ##1 (backlight_level != alc_pkg::ALC_LVL_DAYLIGHT))
    else $error("office comparator did not trip below threshold");

  AST_OFFICE_SCALE: assert property ( // [RL2]
    light_sensor_input.valid && office_compare_enable && office_threshold == 8'hFA
    && light_sensor_input.value == 13'h07CF |=> office_tripped)
    else $error("office threshold code not scaled by eight");

  AST_DAYLIGHT: assert property ( // [RL3]
    light_sensor_input.valid && light_sensor_input.value > office_rel_s && !dark_tripped
    && !dark_compare_enable |=> !office_tripped ##1 (backlight_level == alc_pkg::ALC_LVL_DAYLIGHT))
    else $error("daylight not restored above threshold plus hysteresis");

  AST_OFFICE_HOLD: assert property ( // [RL4]
    office_tripped && office_compare_enable && light_sensor_input.valid
    && light_sensor_input.value >= office_trip_s && light_sensor_input.value <= office_rel_s
    |=> office_tripped)
    else $error("office comparator released inside hysteresis band");

  AST_DARK_TRIP: assert property ( // [RL7]
    light_sensor_input.valid && dark_compare_enable && light_sensor_input.value < {5'h00, dark_threshold}
    |=> dark_tripped ##1 (backlight_level == alc_pkg::ALC_LVL_DARK))
    else $error("dark comparator did not trip below threshold");

  // one code below the top dark code must trip; a level test at the code itself would clash with hold
  AST_DARK_SCALE: assert property ( // [RL8]
    light_sensor_input.valid && dark_compare_enable && dark_threshold == 8'h7F
    && light_sensor_input.value == 13'h007E |=> dark_tripped)
    else $error("dark threshold code not one reading step each");

  AST_PRIORITY: assert property ( // [RL9]
    dark_tripped && office_tripped |=> backlight_level == alc_pkg::ALC_LVL_DARK)
    else $error("office level shown while dark comparator tripped");

  AST_NO_SAMPLE_HOLD: assert property ( // [RL10]
    !light_sensor_input.valid && office_compare_enable && dark_compare_enable
    |=> $stable(office_tripped) && $stable(dark_tripped))
    else $error("comparator moved without a fresh reading");

  AST_DARK_EXIT: assert property ( // [RL11]
    light_sensor_input.valid && light_sensor_input.value > dark_rel_s |=> !dark_tripped)
    else $error("dark level kept above threshold plus hysteresis");

  AST_DARK_HOLD: assert property ( // [RL11]
    dark_tripped && dark_compare_enable && light_sensor_input.valid
    && light_sensor_input.value >= {5'h00, dark_threshold} && light_sensor_input.value <= dark_rel_s
    |=> dark_tripped)
    else $error("dark comparator released inside hysteresis band");

  AST_OFFICE_OFF: assert property ( // [RL9]
    !office_compare_enable |=> !office_tripped)
    else $error("disabled office comparator still tripped");

  AST_DARK_OFF: assert property ( // [RL9]
    !dark_compare_enable |=> !dark_tripped)
    else $error("disabled dark comparator still tripped");

  AST_LEVEL_OFFICE: assert property ( // [RL1]
    office_tripped && !dark_tripped |=> backlight_level == alc_pkg::ALC_LVL_OFFICE)
    else $error("office level not shown for office trip alone");

  AST_LEVEL_DAYLIGHT: assert property ( // [RL3]
    !office_tripped && !dark_tripped |=> backlight_level == alc_pkg::ALC_LVL_DAYLIGHT)
    else $error("daylight level not shown with no comparator tripped");

  AST_REG_WRITE: assert property ( // [RL2]
    reg_write && reg_addr == alc_pkg::OFS_OFFICE_THRESHOLD |=> office_threshold == $past(reg_wdata))
    else $error("office threshold write did not land");

  AST_HYST_WRITE: assert property ( // [RL4]
    reg_write && reg_addr == alc_pkg::OFS_OFFICE_HYSTERESIS |=> office_hysteresis == $past(reg_wdata))
    else $error("office hysteresis write did not land");

  AST_REG_READ: assert property ( // [RL8]
    reg_read && reg_addr == alc_pkg::OFS_DARK_THRESHOLD |=> reg_rdata == $past(dark_threshold))
    else $error("dark threshold read returned wrong data");

  // read data must not drift between reads, software may fetch it late
  AST_RDATA_HOLD: assert property ( // [RL2]
    !reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read strobe");

endmodule : alc_level_cmp

// ### inc/alc_pkg.sv
// ambient light level comparator: shared constants and types
// assumes a single 20 MHz clock and an on-chip converter delivering 13-bit readings
package alc_pkg;

  // clock and conversion timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned REFRESH_MS = 80;
  localparam int unsigned REFRESH_CYCLES = CLK_HZ / 1000 * REFRESH_MS;

  // register offsets
  localparam logic [7:0] OFS_OFFICE_THRESHOLD = 8'h1D;
  localparam logic [7:0] OFS_OFFICE_HYSTERESIS = 8'h1E;
  localparam logic [7:0] OFS_DARK_THRESHOLD = 8'h1F;
  localparam logic [7:0] OFS_DARK_HYSTERESIS = 8'h20;

  // values after reset
  localparam logic [7:0] RST_OFFICE_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_OFFICE_HYSTERESIS = 8'h00;
  localparam logic [7:0] RST_DARK_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_DARK_HYSTERESIS = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // reading width and code scaling; one reading step is one dark step (0.54 uA),
  // an office step (4.3 uA) is taken as eight reading steps
  localparam int unsigned SAMPLE_W = 13;
  localparam int unsigned OFFICE_SHIFT = 3;
  localparam int unsigned DARK_SHIFT = 0;

  typedef enum logic [1:0] {
    ALC_LVL_DAYLIGHT = 2'h0,
    ALC_LVL_OFFICE = 2'h1,
    ALC_LVL_DARK = 2'h3
  } alc_level_t;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] value;
  } alc_sample_t;

endpackage : alc_pkg

// ### sim/alc_level_cmp_tb_top.sv
// bench for the light level comparator: register port, both comparators, level select
// assumes one 20 MHz clock and the strobe register port; the bench drives every port itself
`timescale 1ns/10ps
module alc_level_cmp_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  alc_pkg::alc_sample_t light_sensor_input = '0;
  logic office_compare_enable = 1'b0;
  logic dark_compare_enable = 1'b0;
  logic office_tripped;
  logic dark_tripped;
  alc_pkg::alc_level_t backlight_level;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 62342;
  int t, h, dt, dh;
  logic [7:0] d;
  // slot 4 stands for an unmapped offset and stays zero
  logic [7:0] regs [5] = '{default: 8'h00};
  logic exp_office = 1'b0;
  logic exp_dark = 1'b0;

  always #25 clk = ~clk;

  alc_level_cmp dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .light_sensor_input(light_sensor_input), .office_compare_enable(office_compare_enable),
    .dark_compare_enable(dark_compare_enable), .office_tripped(office_tripped),
    .dark_tripped(dark_tripped), .backlight_level(backlight_level));

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk_reg(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk_reg

  function automatic alc_pkg::alc_level_t exp_level(input logic o, input logic k);
    if (k) return alc_pkg::ALC_LVL_DARK;
    if (o) return alc_pkg::ALC_LVL_OFFICE;
    return alc_pkg::ALC_LVL_DAYLIGHT;
  endfunction : exp_level

  task automatic chk_out(input string what);
    logic [3:0] e;
    e = {exp_office, exp_dark, exp_level(exp_office, exp_dark)};
    n_tests++;
    if ({office_tripped, dark_tripped, backlight_level} !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, e, {office_tripped, dark_tripped, backlight_level});
    end
  endtask : chk_out

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    if (a - 8'h1D < 8'h04) regs[3'(a - 8'h1D)] = v;
    @(negedge clk);
    reg_write = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd

  // the model applies a reading with the enables in force; between the band edges it holds
  task automatic sample(input logic [12:0] v);
    @(negedge clk);
    light_sensor_input.valid = 1'b1;
    light_sensor_input.value = v;
    @(negedge clk);
    light_sensor_input.valid = 1'b0;
    if (!office_compare_enable) exp_office = 1'b0;
    else if (int'(v) < int'(regs[0]) * 8) exp_office = 1'b1;
    else if (int'(v) > (int'(regs[0]) + int'(regs[1])) * 8) exp_office = 1'b0;
    if (!dark_compare_enable) exp_dark = 1'b0;
    else if (int'(v) < int'(regs[2])) exp_dark = 1'b1;
    else if (int'(v) > int'(regs[2]) + int'(regs[3])) exp_dark = 1'b0;
    repeat (2) @(negedge clk);
    chk_out("comparator outputs");
  endtask : sample

  task automatic set_en(input logic o, input logic k);
    @(negedge clk);
    office_compare_enable = o;
    dark_compare_enable = k;
    if (!o) exp_office = 1'b0;
    if (!k) exp_dark = 1'b0;
    repeat (2) @(negedge clk);
    chk_out("enable change");
  endtask : set_en

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(8'h1D + 8'(i), d);
      chk_reg("value after reset", 8'h00, d);
    end
    $display("test reset values done");
    for (int i = 0; i < 5; i++) wr(8'h1D + 8'(i), 8'($random(seed)));
    for (int i = 0; i < 5; i++) begin
      rd(8'h1D + 8'(i), d);
      chk_reg("register readback", regs[i], d);
    end
    $display("test register access done");
    for (int r = 0; r < 20; r++) begin
      t = 1 + int'($unsigned($random(seed)) % 125);
      h = int'($unsigned($random(seed)) % (251 - t)); // office codes and their sum within 250
      dt = 1 + int'($unsigned($random(seed)) % 127);
      dh = int'($unsigned($random(seed)) % 128);
      wr(8'h1D, 8'(t));
      wr(8'h1E, 8'(h));
      wr(8'h1F, 8'(dt));
      wr(8'h20, 8'(dh));
      set_en(r % 4 != 1, r % 4 != 2);
      sample(13'(t * 8));
      sample(13'(t * 8 - 1));
      sample(13'((t + h) * 8));
      sample(13'((t + h) * 8 + 1));
      sample(13'(dt - 1));
      sample(13'(dt + dh));
      sample(13'(dt + dh + 1));
      sample(13'(dt));
      sample(13'h1FFF);
      // readings mostly near the bands, where the trips happen
      repeat (4) sample(13'($unsigned($random(seed)) % 1100));
      set_en(1'b0, 1'b0);
    end
    $display("test comparator rounds done");
    // corner codes: top office code 250 with no hysteresis, top dark code 127
    wr(8'h1D, 8'hFA);
    wr(8'h1E, 8'h00);
    wr(8'h1F, 8'h7F);
    wr(8'h20, 8'h00);
    set_en(1'b1, 1'b1);
    sample(13'h07CF);
    sample(13'h07D0);
    sample(13'h007E);
    sample(13'h007F);
    set_en(1'b0, 1'b0);
    $display("test corner codes done");
    set_en(1'b1, 1'b1);
    sample(13'h0000);
    @(negedge clk);
    rst = 1'b1;
    exp_office = 1'b0;
    exp_dark = 1'b0;
    @(negedge clk);
    chk_out("outputs in reset");
    rst = 1'b0;
    rd(8'h1D, d);
    chk_reg("value after second reset", 8'h00, d);
    $display("test second reset done");
    conclude();
  end

  // the tests need about fourteen hundred cycles; twenty thousand means a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule : alc_level_cmp_tb_top
